// ==== aq_cfg.svh ====
// constants and offsets for the receive queue status and loopback block
// How it works
// - read-only over-level flag for each queue
// - full flag set at 32 queued messages
// - read-only summary flag for each channel
// - select 00 never, 01 nonempty, 10 over, 11 full
// - five-bit level setting, resets to sixteen
// - level zero flags any queued message
// - flag set when count exceeds level N
// - level all ones flags only full queue
// - loopback bit feeds receiver from transmit channel
// - transmit channel k feeds receivers 2k, 2k+1
// - external input ignored while receiver loops back
// - transmit mask input disables transmit pins
// - message is label, 23 data, parity
// - stored bytes: label, 9-16, 17-24, 25-32
// - reversal on receive and before transmit
// - matching label drives chosen bit onto pin
// - monitor configuration resets to zero
// - config byte: channel 7:5, bit 4:0 (8-31)
// - second config byte selects target label
`ifndef AQ_CFG_SVH
`define AQ_CFG_SVH

// register offsets on the host register port
`define AQ_ADDR_SUMMARY      16'h800C
`define AQ_ADDR_LOOPBACK     16'h8022
`define AQ_ADDR_FULL         16'h8029
`define AQ_ADDR_OVER_LEVEL   16'h802A
`define AQ_ADDR_LEVEL        16'h8030
`define AQ_ADDR_MON_PINS     16'h805F
`define AQ_ADDR_MON_BASE     16'h8060
`define AQ_ADDR_MON_LAST     16'h806F

// reset values
`define AQ_RST_LEVEL         5'h10
`define AQ_RST_BYTE          8'h00

// field positions
`define AQ_MON_CHAN_HI       7
`define AQ_MON_CHAN_LO       5
`define AQ_MON_BIT_HI        4
`define AQ_MON_BIT_LO        0

// queue depth and lowest monitorable payload bit
`define AQ_QUEUE_DEPTH       6'h20
`define AQ_MON_MIN_BIT       5'h08

// flag source select encodings
`define AQ_FSEL_NEVER        2'h0
`define AQ_FSEL_NOT_EMPTY    2'h1
`define AQ_FSEL_OVER         2'h2
`define AQ_FSEL_FULL         2'h3

`endif

// ==== aq_pkg.sv ====
// types shared by the receive queue status and loopback block
package aq_pkg;

    typedef logic [5:0]       aq_count_type;
    typedef logic [7:0][5:0]  aq_counts_type;
    typedef logic [7:0][1:0]  aq_fsel_type;

    // host register port request
    typedef struct packed
    {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } aq_host_req_type;

    // one message as the receivers hand it over; bit 0 is serial bit 1
    typedef struct packed
    {
        logic        valid;
        logic [2:0]  chan;
        logic [31:0] word;
    } aq_rx_msg_type;

    // one message as stored: byte 0 at the lowest address
    typedef struct packed
    {
        logic        valid;
        logic [2:0]  chan;
        logic [7:0]  byte3;
        logic [7:0]  byte2;
        logic [7:0]  byte1;
        logic [7:0]  byte0;
    } aq_stored_msg_type;

    // one transmit message in stored order, channel 0 to 3
    typedef struct packed
    {
        logic        valid;
        logic [1:0]  chan;
        logic [31:0] word;
    } aq_tx_msg_type;

    // the whole state of the block
    typedef struct packed
    {
        logic [7:0]        loop;
        logic [4:0]        level;
        logic [7:0][7:0]   mon_cr1;
        logic [7:0][7:0]   mon_cr2;
        logic [7:0]        mon_pins;
        logic [7:0]        over;
        logic [7:0]        full;
        logic [7:0]        summary;
        logic [7:0]        rdata;
        logic              rvalid;
        logic [7:0]        rx_line;
        logic [3:0]        tx_pins;
        aq_stored_msg_type store;
        aq_tx_msg_type     tx_out;
    } aq_state_type;

endpackage

// ==== aq_rx_queue_status.sv ====
// queue flags, loopback routing, label ordering and bit monitor pins
`timescale 1ns/1ps
`default_nettype none
`include "aq_cfg.svh"

module aq_rx_queue_status
    import aq_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire aq_host_req_type host_req,
    output logic [7:0]           host_rdata,
    output logic                 host_rvalid,
    input  wire aq_counts_type   queue_count,
    input  wire aq_fsel_type     flag_source_select,
    input  wire logic [7:0]      ext_rx_line,
    input  wire logic [3:0]      tx_line,
    input  wire logic            transmit_mask_input,
    input  wire logic            label_reverse_enable,
    input  wire logic [7:0]      rx_enable,
    input  wire aq_rx_msg_type   rx_msg,
    input  wire aq_tx_msg_type   tx_msg,
    output logic [7:0]           rx_line_out,
    output logic [3:0]           tx_pins,
    output aq_stored_msg_type    stored_msg,
    output aq_tx_msg_type        tx_serial_msg,
    output logic [7:0]           payload_monitor_pins,
    output logic [7:0]           queue_over_level_flag,
    output logic [7:0]           queue_full_flag,
    output logic [7:0]           queue_summary_flag
);

    aq_state_type st_ff;
    aq_state_type nxt_st;

    // mirror a byte end for end
    function automatic logic [7:0] aq_rev8
    (
        input logic [7:0] b
    );
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

    // index of a monitor configuration register, valid bit on top
    function automatic logic [3:0] aq_mon_index
    (
        input logic [15:0] a
    );
        logic [3:0] r;
        r = 4'h0;
        if ((a >= `AQ_ADDR_MON_BASE) && (a <= `AQ_ADDR_MON_LAST))
        begin
            r = {1'b1, a[3:1]};
        end
        return r;
    endfunction

    // serial word to stored bytes, label reversal applied
    function automatic aq_stored_msg_type aq_to_stored
    (
        input aq_rx_msg_type m,
        input logic          rev
    );
        aq_stored_msg_type s;
        s.valid = m.valid;
        s.chan  = m.chan;
        // unreversed: serial bit 1 lands in the label byte MSB
        s.byte0 = rev ? m.word[7:0] : aq_rev8(m.word[7:0]);
        s.byte1 = m.word[15:8];
        s.byte2 = m.word[23:16];
        s.byte3 = m.word[31:24];
        return s;
    endfunction

    logic [3:0] wr_mon;
    logic [3:0] rd_mon;
    logic [31:0] stored_word;

    // address decode shared by the write and read paths
    assign wr_mon = aq_mon_index(host_req.addr);
    assign rd_mon = wr_mon;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;

        // flags are recomputed every cycle from the live counts, so draining clears them
        for (int k = 0; k < 8; k++)
        begin
            // count above level covers level 0 (nonempty) and 31 (full) alike
            nxt_st.over[k] = queue_count[k] > {1'b0, st_ff.level};
            nxt_st.full[k] = queue_count[k] == `AQ_QUEUE_DEPTH;
            case (flag_source_select[k])
                `AQ_FSEL_NEVER:
                begin
                    nxt_st.summary[k] = 1'b0;
                end
                `AQ_FSEL_NOT_EMPTY:
                begin
                    nxt_st.summary[k] = queue_count[k] != 6'h00;
                end
                `AQ_FSEL_OVER:
                begin
                    nxt_st.summary[k] = queue_count[k] > {1'b0, st_ff.level};
                end
                default:
                begin
                    nxt_st.summary[k] = queue_count[k] == `AQ_QUEUE_DEPTH;
                end
            endcase
        end

        // looped receivers see the paired transmitter, the outside line is dropped
        for (int k = 0; k < 8; k++)
        begin
            nxt_st.rx_line[k] = st_ff.loop[k] ? tx_line[k / 2] : ext_rx_line[k];
        end

        // masked transmit pins rest low so test traffic stays inside
        nxt_st.tx_pins = transmit_mask_input ? 4'h0 : tx_line;

        // received message formatting
        nxt_st.store = aq_to_stored(rx_msg, label_reverse_enable);
        // monitored bit index counts over the stored word, byte 0 lowest
        stored_word = {nxt_st.store.byte3, nxt_st.store.byte2,
                       nxt_st.store.byte1, nxt_st.store.byte0};

        // transmit label put back into serial order just before sending
        nxt_st.tx_out.valid = tx_msg.valid;
        nxt_st.tx_out.chan = tx_msg.chan;
        nxt_st.tx_out.word[31:8] = tx_msg.word[31:8];
        nxt_st.tx_out.word[7:0] = label_reverse_enable ? tx_msg.word[7:0]
                                                       : aq_rev8(tx_msg.word[7:0]);

        // host writes; full, over-level and summary are status and ignore writes
        if (host_req.wr_en)
        begin
            case (host_req.addr)
                `AQ_ADDR_LOOPBACK:
                begin
                    nxt_st.loop = host_req.wdata;
                end
                `AQ_ADDR_LEVEL:
                begin
                    nxt_st.level = host_req.wdata[4:0];
                end
                `AQ_ADDR_MON_PINS:
                begin
                    nxt_st.mon_pins = host_req.wdata;
                end
                default:
                begin
                    if (wr_mon[3])
                    begin
                        if (host_req.addr[0])
                        begin
                            nxt_st.mon_cr2[wr_mon[2:0]] = host_req.wdata;
                        end
                        else
                        begin
                            nxt_st.mon_cr1[wr_mon[2:0]] = host_req.wdata;
                        end
                    end
                end
            endcase
        end

        // a matching message overrides a preset written in the same cycle
        for (int p = 0; p < 8; p++)
        begin
            if (nxt_st.store.valid && rx_enable[nxt_st.store.chan]
                && (nxt_st.store.chan == st_ff.mon_cr1[p][`AQ_MON_CHAN_HI:`AQ_MON_CHAN_LO])
                && (nxt_st.store.byte0 == st_ff.mon_cr2[p])
                && (st_ff.mon_cr1[p][`AQ_MON_BIT_HI:`AQ_MON_BIT_LO] >= `AQ_MON_MIN_BIT))
            begin
                nxt_st.mon_pins[p] =
                    stored_word[st_ff.mon_cr1[p][`AQ_MON_BIT_HI:`AQ_MON_BIT_LO]];
            end
        end

        // host reads answer one cycle later; unmapped addresses read zero
        if (host_req.rd_en)
        begin
            nxt_st.rvalid = 1'b1;
            case (host_req.addr)
                `AQ_ADDR_SUMMARY:
                begin
                    nxt_st.rdata = st_ff.summary;
                end
                `AQ_ADDR_LOOPBACK:
                begin
                    nxt_st.rdata = st_ff.loop;
                end
                `AQ_ADDR_FULL:
                begin
                    nxt_st.rdata = st_ff.full;
                end
                `AQ_ADDR_OVER_LEVEL:
                begin
                    nxt_st.rdata = st_ff.over;
                end
                `AQ_ADDR_LEVEL:
                begin
                    nxt_st.rdata = {3'h0, st_ff.level};
                end
                `AQ_ADDR_MON_PINS:
                begin
                    nxt_st.rdata = st_ff.mon_pins;
                end
                default:
                begin
                    if (rd_mon[3])
                    begin
                        nxt_st.rdata = host_req.addr[0] ? st_ff.mon_cr2[rd_mon[2:0]]
                                                        : st_ff.mon_cr1[rd_mon[2:0]];
                    end
                    else
                    begin
                        nxt_st.rdata = `AQ_RST_BYTE;
                    end
                end
            endcase
        end
    end

    // single state register; synchronous reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_ff <= '0;
            st_ff.level <= `AQ_RST_LEVEL;
            st_ff.mon_cr1 <= '0;
            st_ff.mon_cr2 <= '0;
            st_ff.mon_pins <= `AQ_RST_BYTE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // every output is a flip-flop of the state
    assign host_rdata = st_ff.rdata;
    assign host_rvalid = st_ff.rvalid;
    assign rx_line_out = st_ff.rx_line;
    assign tx_pins = st_ff.tx_pins;
    assign stored_msg = st_ff.store;
    assign tx_serial_msg = st_ff.tx_out;
    assign payload_monitor_pins = st_ff.mon_pins;
    assign queue_over_level_flag = st_ff.over;
    assign queue_full_flag = st_ff.full;
    assign queue_summary_flag = st_ff.summary;

endmodule
`default_nettype wire

// ==== aq_status_asserts.sv ====
// concurrent checks on the ports of the queue status block
`timescale 1ns/1ps
`default_nettype none
module aq_status_asserts
    import aq_pkg::*;
(
    input wire logic              clk,
    input wire logic              srst,
    input wire aq_host_req_type   host_req,
    input wire logic              host_rvalid,
    input wire aq_counts_type     queue_count,
    input wire aq_fsel_type       flag_source_select,
    input wire logic [3:0]        tx_line,
    input wire logic              transmit_mask_input,
    input wire logic              label_reverse_enable,
    input wire aq_rx_msg_type     rx_msg,
    input wire aq_stored_msg_type stored_msg,
    input wire logic [3:0]        tx_pins,
    input wire logic [7:0]        queue_over_level_flag,
    input wire logic [7:0]        queue_full_flag,
    input wire logic [7:0]        queue_summary_flag
);
    logic [7:0]  ne_c;
    logic [7:0]  fu_c;
    logic [7:0]  ne_q;
    logic [7:0]  fu_q;
    logic [7:0]  sum_x;
    logic [7:0]  mir_q;
    aq_fsel_type fs_q;
    logic [1:0]  arm_ff;

    // expected summary from last cycle's inputs; over flag output is registered like the summary so it is used directly
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            ne_c[i] = queue_count[i] != 6'h00;
            fu_c[i] = queue_count[i] == 6'h20;
            case (fs_q[i])
                2'h1: sum_x[i] = ne_q[i];
                2'h2: sum_x[i] = queue_over_level_flag[i];
                2'h3: sum_x[i] = fu_q[i];
                default: sum_x[i] = 1'h0;
            endcase
        end
    end

    // arm two edges after reset so no check looks back into reset
    always_ff @(posedge clk)
    begin
        ne_q <= ne_c;
        fu_q <= fu_c;
        fs_q <= flag_source_select;
        mir_q <= {<<{rx_msg.word[7:0]}};
        arm_ff <= srst ? 2'h0 : {arm_ff[0], 1'h1};
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst || !arm_ff[1]);

    AST_FULL: assert property (queue_full_flag == fu_q)
        else $error("full flag wrong");
    AST_OVER_EMPTY: assert property ((queue_over_level_flag & ~ne_q) == 8'h00)
        else $error("over flag on empty queue");
    AST_FULL_OVER: assert property ((fu_q & ~queue_over_level_flag) == 8'h00)
        else $error("full queue not over level");
    AST_SUMMARY: assert property (queue_summary_flag == sum_x)
        else $error("summary flag wrong");
    AST_RVALID: assert property (host_rvalid == $past(host_req.rd_en))
        else $error("read answer timing wrong");
    AST_MASK: assert property (transmit_mask_input |=> tx_pins == 4'h0)
        else $error("masked transmit pins active");
    AST_TX_PASS: assert property (!transmit_mask_input |=> tx_pins == $past(tx_line))
        else $error("transmit pins differ");
    AST_STORE: assert property (rx_msg.valid |=> stored_msg.valid
        && {stored_msg.byte3, stored_msg.byte2, stored_msg.byte1} == $past(rx_msg.word[31:8]))
        else $error("stored bytes wrong");
    AST_LABEL: assert property (rx_msg.valid |=> stored_msg.byte0 ==
        ($past(label_reverse_enable) ? $past(rx_msg.word[7:0]) : mir_q))
        else $error("label byte order wrong");
endmodule
`default_nettype wire

// ==== aq_host_model.sv ====
// host processor model issuing single register reads and writes
`timescale 1ns/1ps
`default_nettype none
module aq_host_model
    import aq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] host_rdata,
    input  wire logic       host_rvalid,
    output aq_host_req_type host_req
);
    initial host_req = '0;

    // one-cycle strobe, dropped by the edge that takes it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        host_req <= '{1'h1, 1'h0, a, d};
        @(posedge clk);
        host_req <= '0;
    endtask

    // the answer stands for the one cycle after the taking edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
        @(posedge clk);
        host_req <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge clk);
        host_req <= '0;
        #1;
        ok = host_rvalid === 1'h1;
        d = host_rdata;
    endtask
endmodule
`default_nettype wire

// ==== test_a429_rx_queue_status_loopback.sv ====
// self-checking bench for the queue status and loopback block
`timescale 1ns/1ps
`default_nettype none
`include "aq_cfg.svh"
module test_a429_rx_queue_status_loopback
    import aq_pkg::*;
;
    typedef struct packed {logic [5:0] c; logic o; logic f; logic [7:0] s;} aq_row_type;
    typedef struct packed {logic [31:0] w; logic r; logic [7:0] en, b0, m;} aq_rxrow_type;

    logic              clk = 1'h0;
    logic              srst = 1'h1;
    aq_host_req_type   host_req;
    logic [7:0]        host_rdata;
    logic              host_rvalid;
    aq_counts_type     queue_count = '0;
    aq_fsel_type       flag_source_select = 16'hE4E4;
    logic [7:0]        ext_rx_line = 8'h00;
    logic [3:0]        tx_line = 4'h0;
    logic              transmit_mask_input = 1'h0;
    logic              label_reverse_enable = 1'h0;
    logic [7:0]        rx_enable = 8'hFF;
    aq_rx_msg_type     rx_msg = '0;
    aq_tx_msg_type     tx_msg = '0;
    logic [7:0]        rx_line_out;
    logic [3:0]        tx_pins;
    aq_stored_msg_type stored_msg;
    aq_tx_msg_type     tx_serial_msg;
    logic [7:0]        payload_monitor_pins;
    logic [7:0]        queue_over_level_flag;
    logic [7:0]        queue_full_flag;
    logic [7:0]        queue_summary_flag;
    int                n_fail = 0;
    int                tests_run = 0;

    // channel i summary source is i mod 4; s is the expected summary
    aq_row_type rows [7] = '{'{6'h00, 1'h0, 1'h0, 8'h00}, '{6'h01, 1'h0, 1'h0, 8'h22},
        '{6'h10, 1'h0, 1'h0, 8'h22}, '{6'h11, 1'h1, 1'h0, 8'h66},
        '{6'h1F, 1'h1, 1'h0, 8'h66}, '{6'h20, 1'h1, 1'h1, 8'hEE}, '{6'h02, 1'h0, 1'h0, 8'h22}};
    // here s holds the level written, o the expected over flag
    aq_row_type lvls [5] = '{'{6'h01, 1'h1, 1'h0, 8'h00}, '{6'h03, 1'h0, 1'h0, 8'h03},
        '{6'h04, 1'h1, 1'h0, 8'h03}, '{6'h1F, 1'h0, 1'h0, 8'h1F}, '{6'h20, 1'h1, 1'h0, 8'h1F}};
    // monitor pin 0 watches bit 9, pin 1 asks for bit 5 which must do nothing
    aq_rxrow_type rxr [4] = '{'{32'h221, 1'h1, 8'hFF, 8'h21, 8'h01},
        '{32'h221, 1'h0, 8'hFF, 8'h84, 8'h01}, '{32'h084, 1'h0, 8'hFF, 8'h21, 8'h00},
        '{32'h221, 1'h1, 8'hFB, 8'h21, 8'h00}};

    always #10 clk = ~clk;

    aq_rx_queue_status aq_rx_queue_status_i (.clk, .srst, .host_req, .host_rdata, .host_rvalid,
        .queue_count, .flag_source_select, .ext_rx_line, .tx_line, .transmit_mask_input,
        .label_reverse_enable, .rx_enable, .rx_msg, .tx_msg, .rx_line_out, .tx_pins,
        .stored_msg, .tx_serial_msg, .payload_monitor_pins, .queue_over_level_flag,
        .queue_full_flag, .queue_summary_flag);
    aq_host_model aq_host_model_i (.clk, .host_rdata, .host_rvalid, .host_req);

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // a missing answer ends the run at once
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        bit         ok;
        aq_host_model_i.rd(a, v, ok);
        if (!ok)
        begin
            n_fail++;
            final_report;
        end
        else
            chk(v, e);
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic lb(input logic [7:0] x, input logic [3:0] t, input logic m,
        input logic [7:0] er, input logic [3:0] et);
        @(posedge clk);
        ext_rx_line <= x;
        tx_line <= t;
        transmit_mask_input <= m;
        tick();
        chk(rx_line_out, er);
        chk({4'h0, tx_pins}, {4'h0, et});
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        tick();
        chk(queue_summary_flag, 8'h00);
        rdc(`AQ_ADDR_LEVEL, 8'h10);
        rdc(`AQ_ADDR_MON_BASE, 8'h00);
        rdc(`AQ_ADDR_MON_PINS, 8'h00);
        rdc(16'h0000, 8'h00);
        foreach (rows[i])
        begin
            @(posedge clk);
            queue_count <= {8{rows[i].c}};
            tick();
            chk(queue_over_level_flag, {8{rows[i].o}});
            chk(queue_full_flag, {8{rows[i].f}});
            chk(queue_summary_flag, rows[i].s);
            rdc(`AQ_ADDR_OVER_LEVEL, {8{rows[i].o}});
            rdc(`AQ_ADDR_SUMMARY, rows[i].s);
        end
        aq_host_model_i.wr(`AQ_ADDR_FULL, 8'hFF);
        rdc(`AQ_ADDR_FULL, 8'h00);
        foreach (lvls[i])
        begin
            aq_host_model_i.wr(`AQ_ADDR_LEVEL, lvls[i].s);
            rdc(`AQ_ADDR_LEVEL, lvls[i].s);
            @(posedge clk);
            queue_count <= {8{lvls[i].c}};
            tick();
            chk(queue_over_level_flag, {8{lvls[i].o}});
        end
        aq_host_model_i.wr(`AQ_ADDR_LOOPBACK, 8'hA5);
        rdc(`AQ_ADDR_LOOPBACK, 8'hA5);
        lb(8'h0F, 4'h6, 1'h1, 8'h2E, 4'h0);
        lb(8'hF0, 4'h9, 1'h0, 8'hD1, 4'h9);
        aq_host_model_i.wr(`AQ_ADDR_MON_BASE, 8'h49);
        aq_host_model_i.wr(`AQ_ADDR_MON_BASE + 16'h0001, 8'h21);
        aq_host_model_i.wr(`AQ_ADDR_MON_BASE + 16'h0002, 8'h45);
        aq_host_model_i.wr(`AQ_ADDR_MON_BASE + 16'h0003, 8'h21);
        rdc(`AQ_ADDR_MON_BASE, 8'h49);
        foreach (rxr[i])
        begin
            @(posedge clk);
            rx_msg <= '{1'h1, 3'h2, rxr[i].w};
            label_reverse_enable <= rxr[i].r;
            rx_enable <= rxr[i].en;
            @(posedge clk);
            rx_msg.valid <= 1'h0;
            #1;
            chk(stored_msg.byte0, rxr[i].b0);
            chk(stored_msg.byte1, rxr[i].w[15:8]);
            chk(payload_monitor_pins, rxr[i].m);
        end
        @(posedge clk);
        tx_msg <= '{1'h1, 2'h1, 32'h12345601};
        label_reverse_enable <= 1'h0;
        tick();
        chk(tx_serial_msg.word[7:0], 8'h80);
        chk(tx_serial_msg.word[31:24], 8'h12);
        @(posedge clk);
        srst <= 1'h1;
        @(posedge clk);
        srst <= 1'h0;
        tick();
        rdc(`AQ_ADDR_MON_BASE, 8'h00);
        rdc(`AQ_ADDR_LOOPBACK, 8'h00);
        final_report;
    end
endmodule

bind aq_rx_queue_status aq_status_asserts aq_status_asserts_i (.clk, .srst, .host_req,
    .host_rvalid, .queue_count, .flag_source_select, .tx_line, .transmit_mask_input,
    .label_reverse_enable, .rx_msg, .stored_msg, .tx_pins, .queue_over_level_flag,
    .queue_full_flag, .queue_summary_flag);
`default_nettype wire
